// ===== pmc_consts.svh
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH
// Contract
// R01 - First port has seven pins, each with its own direction bit
// R02 - First port pins each have a per-bit selectable pull-up
// R03 - Second port has eight pins with per-bit direction
// R04 - Second port pins each have a per-bit selectable pull-up
// R05 - Port or control mode is chosen for every pin on its own
// R06 - Third port has eight pins, each also an analog channel input
// R07 - After reset, analog-shared pins sit in analog input state
// R08 - After reset, other shared pins come up as digital inputs
// R09 - Edge interrupt input detects rising, falling or both edges
// R10 - Primary timer pin feeds count and two captures; secondary one capture
// R11 - Third port pins enter analog input mode at reset release
// R12 - Control mode: peripheral output drives pin; inputs get synced pin level

`define PMC_A_W        7
`define PMC_B_W        8
`define PMC_C_W        8
`define PMC_A_MASK     8'h7f
`define PMC_B_MASK     8'hff
`define PMC_C_MASK     8'hff
`define PMC_DIR_RST    8'hff
`define PMC_PU_RST     8'h00
`define PMC_LAT_RST    8'h00
`define PMC_CTL_RST    8'h00
`define PMC_CTL_C_RST  8'hff
`define PMC_EDGE_BIT   6
`define PMC_TCC_BIT    0
`define PMC_TCO_BIT    1
`define PMC_PORT_A     2'h0
`define PMC_PORT_B     2'h1
`define PMC_PORT_C     2'h2
`define PMC_FLD_DIR    2'h0
`define PMC_FLD_PU     2'h1
`define PMC_FLD_CTL    2'h2
`define PMC_FLD_LAT    2'h3
`define PMC_EDGE_NONE  2'h0
`define PMC_EDGE_RISE  2'h1
`define PMC_EDGE_FALL  2'h2
`define PMC_EDGE_BOTH  2'h3
`endif

// ===== pmc_pkg.sv
`include "pmc_consts.svh"
package pmc_pkg;
  typedef enum logic [1:0] {
    PMC_PA = `PMC_PORT_A,
    PMC_PB = `PMC_PORT_B,
    PMC_PC = `PMC_PORT_C
  } pmc_port_e;

  typedef enum logic [1:0] {
    PMC_DIR = `PMC_FLD_DIR,
    PMC_PU  = `PMC_FLD_PU,
    PMC_CTL = `PMC_FLD_CTL,
    PMC_LAT = `PMC_FLD_LAT
  } pmc_field_e;

  typedef enum logic [1:0] {
    PMC_E_NONE = `PMC_EDGE_NONE,
    PMC_E_RISE = `PMC_EDGE_RISE,
    PMC_E_FALL = `PMC_EDGE_FALL,
    PMC_E_BOTH = `PMC_EDGE_BOTH
  } pmc_edge_e;

  typedef struct packed {
    logic       en;
    pmc_port_e  port;
    pmc_field_e field;
    logic [7:0] data;
  } pmc_wr_s;

  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] pu;
    logic [7:0] ctl;
    logic [7:0] lat;
  } pmc_cfg_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
  } pmc_pin_s;

  typedef struct packed {
    pmc_cfg_s   cfg;
    logic [7:0] s1;
    logic [7:0] s2;
    pmc_pin_s   drv;
    logic [7:0] rd;
    logic [7:0] alt_in;
  } pmc_port_s;

  typedef struct packed {
    pmc_port_s a;
    pmc_port_s b;
    pmc_port_s c;
    logic      tcnt;
    logic      cap_dual;
    logic      cap_single;
  } pmc_state_s;

  typedef struct packed {
    logic prev;
    logic irq;
  } pmc_edge_s;
endpackage

// ===== pmc_edge_det.sv
`timescale 1ns/10ps
module pmc_edge_det import pmc_pkg::*; (
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire logic      ce,
  input  wire logic      level,
  input  wire logic      enable,
  input  wire pmc_edge_e mode,
  output logic           irq_q
);
  pmc_edge_s st_q;
  pmc_edge_s st_d;
  logic      rise;
  logic      fall;

  assign rise = level & ~st_q.prev;
  assign fall = ~level & st_q.prev;

  always_comb begin
    st_d      = st_q;
    st_d.prev = level;
    st_d.irq  = 1'b0;
    if (enable) begin
      unique case (mode) // R09
        PMC_E_NONE: st_d.irq = 1'b0;
        PMC_E_RISE: st_d.irq = rise;
        PMC_E_FALL: st_d.irq = fall;
        PMC_E_BOTH: st_d.irq = rise | fall;
      endcase
    end
  end

  // Prev starts low, so a pin already high at reset fires one rising edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign irq_q = st_q.irq;
endmodule

// ===== pmc_port_top.sv
`timescale 1ns/10ps
module pmc_port_top import pmc_pkg::*; (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire pmc_wr_s              cfg_wr,
  input  wire pmc_edge_e            edge_mode,
  input  wire logic [`PMC_A_W-1:0]  port_a_pins_in,
  output logic      [`PMC_A_W-1:0]  port_a_pins_out,
  output logic      [`PMC_A_W-1:0]  port_a_pins_oe,
  output logic      [`PMC_A_W-1:0]  port_a_pullup_on,
  input  wire logic [`PMC_B_W-1:0]  port_b_pins_in,
  output logic      [`PMC_B_W-1:0]  port_b_pins_out,
  output logic      [`PMC_B_W-1:0]  port_b_pins_oe,
  output logic      [`PMC_B_W-1:0]  port_b_pullup_on,
  input  wire logic [`PMC_C_W-1:0]  port_c_pins_in,
  output logic      [`PMC_C_W-1:0]  port_c_pins_out,
  output logic      [`PMC_C_W-1:0]  port_c_pins_oe,
  input  wire logic [`PMC_A_W-1:0]  port_a_alt_out,
  input  wire logic [`PMC_A_W-1:0]  port_a_alt_oe,
  input  wire logic [`PMC_B_W-1:0]  port_b_alt_out,
  input  wire logic [`PMC_B_W-1:0]  port_b_alt_oe,
  output logic      [`PMC_A_W-1:0]  port_a_alt_in,
  output logic      [`PMC_B_W-1:0]  port_b_alt_in,
  output logic      [`PMC_A_W-1:0]  port_a_read,
  output logic      [`PMC_B_W-1:0]  port_b_read,
  output logic      [`PMC_C_W-1:0]  port_c_read,
  output logic      [`PMC_C_W-1:0]  analog_channel_inputs,
  output logic                      timer_count_clk,
  output logic                      timer_capture_dual_trig,
  output logic                      timer_capture_single_trig,
  output logic                      edge_interrupt_req
);
  pmc_state_s st_q;
  pmc_state_s st_d;
  logic       edge_irq;

  // One update shared by all three ports
  function automatic pmc_port_s port_next(
    input pmc_port_s  cur,
    input pmc_wr_s    wr,
    input pmc_port_e  id,
    input logic [7:0] mask,
    input logic       has_pu,
    input logic       analog,
    input logic [7:0] pins,
    input logic [7:0] aout,
    input logic [7:0] aoe
  );
    pmc_port_s  nx;
    logic [7:0] dig;
    logic [7:0] ctl_out;
    nx = cur;
    if (wr.en && wr.port == id) begin
      unique case (wr.field)
        PMC_DIR: nx.cfg.dir = wr.data & mask; // R01 R03
        PMC_PU:  nx.cfg.pu  = has_pu ? (wr.data & mask) : 8'h00; // R02 R04
        PMC_CTL: nx.cfg.ctl = wr.data & mask; // R05
        PMC_LAT: nx.cfg.lat = wr.data & mask;
      endcase
    end
    // Analog pins lose digital drive, pull-up and readback
    dig     = analog ? ~cur.cfg.ctl : 8'hff; // R06
    ctl_out = cur.cfg.ctl & aoe & dig;
    nx.s1   = pins & mask;
    nx.s2   = cur.s1;
    nx.drv.oe  = mask & dig & ((cur.cfg.ctl & aoe) | (~cur.cfg.ctl & ~cur.cfg.dir)); // R12
    nx.drv.out = mask & ((ctl_out & aout) | (~ctl_out & cur.cfg.lat)); // R12
    nx.drv.pu  = mask & dig & cur.cfg.pu & ~nx.drv.oe; // R02 R04
    nx.rd      = cur.s2 & dig;
    // Input functions see the pin, never the output latch
    nx.alt_in  = cur.s2 & cur.cfg.ctl & ~aoe & dig; // R12
    return nx;
  endfunction

  always_comb begin
    st_d   = st_q;
    st_d.a = port_next(st_q.a, cfg_wr, PMC_PA, `PMC_A_MASK, 1'b1, 1'b0,
                       {1'b0, port_a_pins_in}, {1'b0, port_a_alt_out},
                       {1'b0, port_a_alt_oe});
    st_d.b = port_next(st_q.b, cfg_wr, PMC_PB, `PMC_B_MASK, 1'b1, 1'b0,
                       port_b_pins_in, port_b_alt_out, port_b_alt_oe);
    st_d.c = port_next(st_q.c, cfg_wr, PMC_PC, `PMC_C_MASK, 1'b0, 1'b1,
                       port_c_pins_in, 8'h00, 8'h00); // R06
    // Primary pin: count clock and dual capture trigger
    st_d.tcnt       = st_q.a.cfg.ctl[`PMC_TCC_BIT] & st_q.a.s2[`PMC_TCC_BIT]; // R10
    st_d.cap_dual   = st_q.a.cfg.ctl[`PMC_TCC_BIT] & st_q.a.s2[`PMC_TCC_BIT]; // R10
    // Secondary pin shares its pad with a timer output
    st_d.cap_single = st_q.a.cfg.ctl[`PMC_TCO_BIT] & ~port_a_alt_oe[`PMC_TCO_BIT]
                      & st_q.a.s2[`PMC_TCO_BIT]; // R10
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q           <= '0;
      st_q.a.cfg.dir <= `PMC_DIR_RST; // R08
      st_q.a.cfg.pu  <= `PMC_PU_RST;
      st_q.a.cfg.ctl <= `PMC_CTL_RST; // R08
      st_q.a.cfg.lat <= `PMC_LAT_RST;
      st_q.b.cfg.dir <= `PMC_DIR_RST; // R08
      st_q.b.cfg.pu  <= `PMC_PU_RST;
      st_q.b.cfg.ctl <= `PMC_CTL_RST; // R08
      st_q.b.cfg.lat <= `PMC_LAT_RST;
      st_q.c.cfg.dir <= `PMC_DIR_RST;
      st_q.c.cfg.pu  <= `PMC_PU_RST;
      st_q.c.cfg.ctl <= `PMC_CTL_C_RST; // R07 R11
      st_q.c.cfg.lat <= `PMC_LAT_RST;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  pmc_edge_det u_edge (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .level  (st_q.b.s2[`PMC_EDGE_BIT]),
    .enable (st_q.b.cfg.ctl[`PMC_EDGE_BIT]), // R09
    .mode   (edge_mode),
    .irq_q  (edge_irq)
  );

  assign port_a_pins_out           = st_q.a.drv.out[`PMC_A_W-1:0];
  assign port_a_pins_oe            = st_q.a.drv.oe[`PMC_A_W-1:0];
  assign port_a_pullup_on          = st_q.a.drv.pu[`PMC_A_W-1:0];
  assign port_b_pins_out           = st_q.b.drv.out;
  assign port_b_pins_oe            = st_q.b.drv.oe;
  assign port_b_pullup_on          = st_q.b.drv.pu;
  assign port_c_pins_out           = st_q.c.drv.out;
  assign port_c_pins_oe            = st_q.c.drv.oe;
  assign port_a_alt_in             = st_q.a.alt_in[`PMC_A_W-1:0];
  assign port_b_alt_in             = st_q.b.alt_in;
  assign port_a_read               = st_q.a.rd[`PMC_A_W-1:0];
  assign port_b_read               = st_q.b.rd;
  assign port_c_read               = st_q.c.rd;
  assign analog_channel_inputs     = st_q.c.cfg.ctl; // R06 R07
  assign timer_count_clk           = st_q.tcnt;
  assign timer_capture_dual_trig   = st_q.cap_dual;
  assign timer_capture_single_trig = st_q.cap_single;
  assign edge_interrupt_req        = edge_irq;
endmodule

// ===== pmc_port_props.sv
`timescale 1ns/10ps
module pmc_port_props import pmc_pkg::*; (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire pmc_wr_s    cfg_wr,
  input wire pmc_edge_e  edge_mode,
  input wire logic [6:0] port_a_pins_oe,
  input wire logic [7:0] port_b_pins_out,
  input wire logic [7:0] port_b_alt_out,
  input wire logic [7:0] port_b_alt_oe,
  input wire logic [6:0] port_a_alt_in,
  input wire logic [6:0] port_a_read,
  input wire logic [7:0] port_b_read,
  input wire logic [7:0] analog_channel_inputs,
  input wire logic       timer_count_clk,
  input wire logic       timer_capture_dual_trig,
  input wire logic       timer_capture_single_trig,
  input wire logic       edge_interrupt_req
);
  logic [7:0] ctl_a_q, ctl_b_q;
  // Shadow of the mode selects, rebuilt from the write strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_a_q <= 8'h00;
      ctl_b_q <= 8'h00;
    end else if (ce && cfg_wr.en && cfg_wr.field == PMC_CTL) begin
      if (cfg_wr.port == PMC_PA) ctl_a_q <= cfg_wr.data;
      if (cfg_wr.port == PMC_PB) ctl_b_q <= cfg_wr.data;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_dir_wr;
    ce && cfg_wr.en && cfg_wr.port == PMC_PA && cfg_wr.field == PMC_DIR && ctl_a_q == 8'h00 ##1 ce;
  endsequence
  sequence s_rise_req;
    edge_interrupt_req && edge_mode == PMC_E_RISE;
  endsequence
  rst_state_a: assert property ($fell(rst) |-> analog_channel_inputs == 8'hff &&
    port_a_pins_oe == 7'h00) else $error("state after reset wrong");
  dir_write_a: assert property (s_dir_wr |=> port_a_pins_oe == ~$past(cfg_wr.data[6:0], 2))
    else $error("direction write not applied");
  timer_same_a: assert property (timer_count_clk == timer_capture_dual_trig)
    else $error("count and dual capture differ");
  timer_pin_a: assert property (timer_count_clk == ($past(ctl_a_q[0]) && port_a_read[0]))
    else $error("count clock not pin level");
  timer_src_a: assert property (timer_count_clk || timer_capture_single_trig |->
    $past(ctl_a_q[0]) || $past(ctl_a_q[1])) else $error("timer input without control mode");
  alt_gate_a: assert property ((port_a_alt_in & ~port_a_read) == 7'h00)
    else $error("peripheral input not pin level");
  edge_none_a: assert property ((ce && edge_mode == PMC_E_NONE)[*3] |=> !edge_interrupt_req)
    else $error("edge request with no edge selected");
  edge_rise_a: assert property (s_rise_req |-> $rose(port_b_read[6]))
    else $error("rising request without rising pin");
  edge_chg_a: assert property (edge_interrupt_req |-> $changed(port_b_read[6]))
    else $error("edge request without pin change");
  alt_drive_a: assert property (ce |=> (port_b_pins_out & $past(ctl_b_q & port_b_alt_oe)) ==
    $past(port_b_alt_out & ctl_b_q & port_b_alt_oe)) else $error("peripheral not driving pin");
endmodule
bind pmc_port_top pmc_port_props u_props (.clk, .rst, .ce, .cfg_wr, .edge_mode,
  .port_a_pins_oe, .port_b_pins_out, .port_b_alt_out, .port_b_alt_oe, .port_a_alt_in,
  .port_a_read, .port_b_read, .analog_channel_inputs, .timer_count_clk,
  .timer_capture_dual_trig, .timer_capture_single_trig, .edge_interrupt_req);

// ===== pmc_board_model.sv
`timescale 1ns/10ps
module pmc_board_model #(parameter int W = 8) (
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] pu,
  input  wire logic [W-1:0] ext_en,
  input  wire logic [W-1:0] ext_val,
  output logic      [W-1:0] level
);
  // Undriven pin without pull-up settles low on this board
  assign level = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & pu);
endmodule

// ===== tb_port_pin_mode_control.sv
`timescale 1ns/10ps
module tb_port_pin_mode_control import pmc_pkg::*; ;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1;
  pmc_wr_s   cfg_wr = '0;
  pmc_edge_e edge_mode = PMC_E_NONE;
  logic [6:0] port_a_pins_in, port_a_pins_out, port_a_pins_oe, port_a_pullup_on, port_a_alt_in;
  logic [6:0] port_a_read, port_a_alt_out = '0, port_a_alt_oe = '0, ea = '0, ea_en = '0;
  logic [7:0] port_b_pins_in, port_b_pins_out, port_b_pins_oe, port_b_pullup_on, port_b_alt_in;
  logic [7:0] port_b_read, port_b_alt_out = '0, port_b_alt_oe = '0, eb = '0, eb_en = '0;
  logic [7:0] port_c_pins_in, port_c_pins_out, port_c_pins_oe, port_c_read, analog_channel_inputs;
  logic [7:0] ec = '1, ec_en = '1;
  logic       timer_count_clk, timer_capture_dual_trig, timer_capture_single_trig;
  logic       edge_interrupt_req;
  int         n_mismatch = 0, checked = 0;
  pmc_port_top dut_u (.*);
  pmc_board_model #(.W(7)) pa_u (.oe(port_a_pins_oe), .out(port_a_pins_out),
    .pu(port_a_pullup_on), .ext_en(ea_en), .ext_val(ea), .level(port_a_pins_in));
  pmc_board_model #(.W(8)) pb_u (.oe(port_b_pins_oe), .out(port_b_pins_out),
    .pu(port_b_pullup_on), .ext_en(eb_en), .ext_val(eb), .level(port_b_pins_in));
  pmc_board_model #(.W(8)) pc_u (.oe(port_c_pins_oe), .out(port_c_pins_out),
    .pu(8'h00), .ext_en(ec_en), .ext_val(ec), .level(port_c_pins_in));
  always #25 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input pmc_port_e p, input pmc_field_e f, input logic [7:0] d);
    @(posedge clk);
    #2 cfg_wr = '{1'b1, p, f, d};
    @(posedge clk);
    #2 cfg_wr.en = 1'b0;
  endtask
  // Covers the two sync stages plus output register and board loop
  task automatic settle;
    repeat (5) @(posedge clk);
    #2;
  endtask
  task automatic t_dir_pu;
    wr(PMC_PA, PMC_LAT, 8'h55);
    wr(PMC_PA, PMC_DIR, 8'h0f);
    wr(PMC_PA, PMC_PU, 8'hff);
    wr(PMC_PB, PMC_DIR, 8'h3c);
    wr(PMC_PB, PMC_PU, 8'hff);
    settle;
    chk({1'b0, port_a_pins_oe}, 8'h70);
    chk({1'b0, port_a_read}, 8'h5f);
    chk({1'b0, port_a_pins_out}, 8'h55);
    chk({1'b0, port_a_pullup_on}, 8'h0f);
    chk(port_b_pins_oe, 8'hc3);
    chk(port_b_pullup_on, 8'h3c);
    ce = 1'b0;
    wr(PMC_PB, PMC_DIR, 8'h00);
    ce = 1'b1;
    settle;
    chk(port_b_pins_oe, 8'hc3);
    port_b_alt_oe = 8'hff;
    port_b_alt_out = 8'hff;
    wr(PMC_PB, PMC_CTL, 8'h04);
    settle;
    chk(port_b_pins_oe, 8'hc7);
    chk(port_b_pins_out, 8'h04);
    wr(PMC_PB, PMC_CTL, 8'h00);
    wr(PMC_PB, PMC_DIR, 8'hff);
    wr(PMC_PB, PMC_PU, 8'h00);
  endtask
  task automatic t_analog;
    chk(analog_channel_inputs, 8'hff);
    chk(port_c_read, 8'h00);
    wr(PMC_PC, PMC_CTL, 8'h0f);
    wr(PMC_PC, PMC_DIR, 8'h00);
    wr(PMC_PC, PMC_LAT, 8'ha0);
    settle;
    chk(analog_channel_inputs, 8'h0f);
    chk(port_c_pins_oe, 8'hf0);
    chk(port_c_pins_out, 8'ha0);
    chk(port_c_read, 8'ha0);
  endtask
  task automatic t_timer;
    wr(PMC_PA, PMC_CTL, 8'h03);
    ea_en = 7'h7f;
    ea = 7'h03;
    settle;
    chk({5'h0, timer_count_clk, timer_capture_dual_trig, timer_capture_single_trig}, 8'h07);
    chk({1'b0, port_a_alt_in}, 8'h03);
    ea = 7'h02;
    settle;
    chk({5'h0, timer_count_clk, timer_capture_dual_trig, timer_capture_single_trig}, 8'h01);
  endtask
  task automatic t_edge;
    int n;
    logic [7:0] exp_n [4] = '{8'h00, 8'h01, 8'h01, 8'h02};
    // Interrupt pin is an input function, so the peripheral must not drive it
    port_b_alt_oe = 8'h00;
    eb_en = 8'hff;
    wr(PMC_PB, PMC_CTL, 8'h40);
    for (int i = 0; i < 4; i++) begin
      edge_mode = pmc_edge_e'(i);
      n = 0;
      for (int k = 0; k < 20; k++) begin
        @(posedge clk);
        #2;
        if (k == 2) eb[6] = 1'b1;
        if (k == 10) eb[6] = 1'b0;
        if (edge_interrupt_req === 1'b1) n++;
      end
      chk(8'(n), exp_n[i]);
    end
    eb = 8'h40;
    settle;
    chk(port_b_alt_in, 8'h40);
    chk(port_b_read, 8'h40);
  endtask
  task automatic final_report;
    $display("mismatches=%0d checks=%0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #2 rst = 1'b0;
    chk({1'b0, port_a_pins_oe}, 8'h00);
    chk(port_b_pins_oe, 8'h00);
    t_analog();
    t_dir_pu();
    t_timer();
    t_edge();
    final_report();
  end
endmodule
